// ### design/cef_consts.svh
// Constants for the receive and transmit-event object formatter
`ifndef CEF_CONSTS_SVH
`define CEF_CONSTS_SVH

// Object word 0: identifier fields
`define CEF_W0_STD_LSB      0
`define CEF_W0_STD_MSB      10
`define CEF_W0_EXT_LSB      11
`define CEF_W0_EXT_MSB      28
`define CEF_W0_HIGH_BIT     29

// Object word 1: filter index, error state, frame flags, sequence tag
`define CEF_W1_DLC_LSB      0
`define CEF_W1_DLC_MSB      3
`define CEF_W1_IDE_BIT      4
`define CEF_W1_RTR_BIT      5
`define CEF_W1_BRS_BIT      6
`define CEF_W1_FDF_BIT      7
`define CEF_W1_ESI_BIT      8
`define CEF_W1_SEQ_LSB      9
`define CEF_W1_SEQ_MSB      31
`define CEF_W1_FILT_LSB     11
`define CEF_W1_FILT_MSB     15

// Register byte addresses on the APB side
`define CEF_REG_CTRL        12'h000
`define CEF_REG_STATUS      12'h004
`define CEF_REG_TIME        12'h008

// Control register fields
`define CEF_CTRL_STORE_BIT  0
`define CEF_CTRL_RXTS_BIT   1
`define CEF_CTRL_EVTS_BIT   2
`define CEF_CTRL_PSZ_LSB    4
`define CEF_CTRL_PSZ_MSB    6

// Status register fields
`define CEF_STAT_RX_LSB     0
`define CEF_STAT_RX_MSB     15
`define CEF_STAT_EV_LSB     16
`define CEF_STAT_EV_MSB     31

// Reset values
`define CEF_RST_CTRL_STORE  1'b0
`define CEF_RST_CTRL_RXTS   1'b0
`define CEF_RST_CTRL_EVTS   1'b0
`define CEF_RST_CTRL_PSZ    3'h0

`endif

// ### design/cef_pkg.sv
// Types shared by the object formatter
package cef_pkg;

   // Formatter sequence states
   typedef enum logic [2:0] {
      CEF_ST_IDLE  = 3'b000,
      CEF_ST_ID    = 3'b001,
      CEF_ST_FLAGS = 3'b010,
      CEF_ST_STAMP = 3'b011,
      CEF_ST_DATA  = 3'b100
   } cef_state_t;

   // Complete state of the formatter top
   typedef struct packed {
      cef_state_t         st;
      logic [31:0]        w0;
      logic [31:0]        w1;
      logic [31:0]        stamp;
      logic [15:0][31:0]  pay;
      logic               is_rx;
      logic               stamp_on;
      logic [3:0]         widx;
      logic [3:0]         wlast;
      logic [31:0]        tbase;
      logic [15:0]        n_rx;
      logic [15:0]        n_ev;
      logic               ev_store;
      logic               rx_stamp;
      logic               ev_stamp;
      logic [2:0]         psize;
      logic               pready;
      logic               pslverr;
      logic [31:0]        prdata;
      logic               rx_ready;
      logic               tx_ready;
      logic               ov;
      logic [31:0]        od;
      logic               ol;
      logic               okind;
   } cef_regs_t;

endpackage

// ### design/cef_fifo.sv
// Small word FIFO between the formatter and the message RAM port
`timescale 1ns/1ps
module cef_fifo
   import cef_pkg::*;
#(
   parameter int WIDTH = 34,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input  wire logic             pclk,
   input  wire logic             presetn,
   // Filling side
   input  wire logic             in_valid,
   output      logic             in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Draining side
   output      logic             out_valid,
   input  wire logic             out_ready,
   output      logic [WIDTH-1:0] out_data
);

   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   // Pointers wrap by hand, so any depth of two or more is served
   generate
      if (DEPTH < 2 || WIDTH < 1) begin : g_bad
         $error("cef_fifo needs DEPTH of at least 2 and WIDTH of at least 1");
      end
   endgenerate

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               rd;
      logic [AW-1:0]               wr;
      logic [AW:0]                 cnt;
   } cef_fifo_state_t;

   cef_fifo_state_t r;
   cef_fifo_state_t n;
   logic            push;
   logic            pop;

   ////////////////////////////////////////////////////////////////////////////
   // Full and empty come straight from the occupancy count
   assign in_ready  = (r.cnt != (AW+1)'(DEPTH));
   assign out_valid = (r.cnt != '0);
   assign out_data  = r.mem[r.rd];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // Next state
   always_comb begin
      n = r;
      if (push) begin
         n.mem[r.wr] = in_data;
         n.wr        = (r.wr == AW'(DEPTH-1)) ? '0 : r.wr + AW'(1);
      end
      if (pop) begin
         n.rd = (r.rd == AW'(DEPTH-1)) ? '0 : r.rd + AW'(1);
      end
      if (push & ~pop) begin
         n.cnt = r.cnt + (AW+1)'(1);
      end else if (pop & ~push) begin
         n.cnt = r.cnt - (AW+1)'(1);
      end
   end

   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

endmodule

// ### design/cef_object_writer.sv
// Formats receive and transmit-event objects into message RAM words
//
// Notes on behaviour
// - Word 0: std id 10:0, ext 28:11, bit 29
// - Unused receive bits are written as zero
// - Receive word 1 bits 15:11 hold filter index
// - Word 1 bit 8: error passive when set
// - Receive word 1 low byte holds frame flags
// - Receive stamp word only when rx stamping enabled
// - Payload four bytes per word, ascending order
// - Event word 0 repeats the sent identifier
// - Event word 1 bits 31:9 hold sequence tag
// - Event word 1 low byte holds sent flags
// - Event stamp word only when event stamping enabled
// - Events stored only when event storing enabled
`timescale 1ns/1ps
`include "cef_consts.svh"
module cef_object_writer
   import cef_pkg::*;
#(
   parameter int FIFO_DEPTH = 4
) (
   // Clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   // APB register port
   input  wire logic         psel,
   input  wire logic         penable,
   input  wire logic         pwrite,
   input  wire logic [11:0]  paddr,
   input  wire logic [31:0]  pwdata,
   output      logic [31:0]  prdata,
   output      logic         pready,
   output      logic         pslverr,
   // Received frame from the protocol engine
   input  wire logic         rx_frame_valid,
   output      logic         rx_frame_ready,
   input  wire logic [10:0]  rx_std_identifier,
   input  wire logic [17:0]  rx_ext_identifier,
   input  wire logic         rx_std_id_high_bit,
   input  wire logic [4:0]   rx_filter_match_idx,
   input  wire logic         rx_esi,
   input  wire logic         rx_fdf,
   input  wire logic         rx_brs,
   input  wire logic         rx_rtr,
   input  wire logic         rx_ide,
   input  wire logic [3:0]   rx_dlc,
   input  wire logic [511:0] rx_payload,
   // Transmitted frame event from the protocol engine
   input  wire logic         tx_event_valid,
   output      logic         tx_event_ready,
   input  wire logic [10:0]  tx_std_identifier,
   input  wire logic [17:0]  tx_ext_identifier,
   input  wire logic         tx_std_id_high_bit,
   input  wire logic [22:0]  tx_sequence_tag,
   input  wire logic         tx_esi,
   input  wire logic         tx_fdf,
   input  wire logic         tx_brs,
   input  wire logic         tx_rtr,
   input  wire logic         tx_ide,
   input  wire logic [3:0]   tx_dlc,
   // Object words toward the message RAM
   output      logic         obj_word_valid,
   input  wire logic         obj_word_ready,
   output      logic [31:0]  obj_word_data,
   output      logic         obj_word_last,
   output      logic         obj_word_is_rx
);

   localparam int FW = 34;

   generate
      if (FIFO_DEPTH < 2) begin : g_bad
         $error("cef_object_writer needs FIFO_DEPTH of at least 2");
      end
   endgenerate

   cef_regs_t         r;
   cef_regs_t         n;
   logic              push_valid;
   logic [31:0]       push_word;
   logic              push_last;
   logic              push_ready;
   logic              fifo_valid;
   logic [FW-1:0]     fifo_data;
   logic              fifo_pop;
   logic              apb_setup;
   logic              apb_done;
   logic              rx_take;
   logic              tx_take;

   ////////////////////////////////////////////////////////////////////////////
   // Index of the last payload word per receive object for each size setting
   function automatic logic [3:0] last_word(input logic [2:0] sel);
      case (sel)
         3'h0:    last_word = 4'h1;
         3'h1:    last_word = 4'h2;
         3'h2:    last_word = 4'h3;
         3'h3:    last_word = 4'h4;
         3'h4:    last_word = 4'h5;
         3'h5:    last_word = 4'h7;
         3'h6:    last_word = 4'hb;
         default: last_word = 4'hf;
      endcase
   endfunction

   // Handshakes; a receive frame wins when both arrive together
   assign apb_setup = psel & penable & ~r.pready;
   assign apb_done  = psel & penable & r.pready;
   assign rx_take   = rx_frame_valid & r.rx_ready;
   assign tx_take   = tx_event_valid & r.tx_ready & ~rx_frame_valid;
   assign fifo_pop  = fifo_valid & (~r.ov | obj_word_ready);

   ////////////////////////////////////////////////////////////////////////////
   // Word offered to the FIFO in each state
   always_comb begin
      push_valid = 1'b0;
      push_word  = '0;
      push_last  = 1'b0;
      case (r.st)
         CEF_ST_ID: begin
            push_valid = 1'b1;
            push_word  = r.w0;
         end
         CEF_ST_FLAGS: begin
            push_valid = 1'b1;
            push_word  = r.w1;
            push_last  = ~r.is_rx & ~r.stamp_on;
         end
         CEF_ST_STAMP: begin
            push_valid = 1'b1;
            push_word  = r.stamp;
            push_last  = ~r.is_rx;
         end
         CEF_ST_DATA: begin
            push_valid = 1'b1;
            push_word  = r.pay[r.widx];
            push_last  = (r.widx == r.wlast);
         end
         default: begin
            push_valid = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next state of the whole block
   always_comb begin
      n = r;
      // Time base runs every cycle and never stops
      n.tbase = r.tbase + 32'h1;

      // Register reads answer one cycle into the access phase
      n.pready  = apb_setup;
      n.pslverr = 1'b0;
      if (apb_setup && !pwrite) begin
         case (paddr)
            `CEF_REG_CTRL: begin
               n.prdata = '0;
               n.prdata[`CEF_CTRL_STORE_BIT] = r.ev_store;
               n.prdata[`CEF_CTRL_RXTS_BIT]  = r.rx_stamp;
               n.prdata[`CEF_CTRL_EVTS_BIT]  = r.ev_stamp;
               n.prdata[`CEF_CTRL_PSZ_MSB:`CEF_CTRL_PSZ_LSB] = r.psize;
            end
            `CEF_REG_STATUS: begin
               n.prdata = {r.n_ev, r.n_rx};
            end
            `CEF_REG_TIME: begin
               n.prdata = r.tbase;
            end
            default: begin
               n.prdata  = '0;
               n.pslverr = 1'b1;
            end
         endcase
      end else if (apb_setup) begin
         n.prdata  = '0;
         n.pslverr = (paddr != `CEF_REG_CTRL);
      end
      // Write lands at the edge that completes the transfer
      if (apb_done && pwrite && paddr == `CEF_REG_CTRL) begin
         n.ev_store = pwdata[`CEF_CTRL_STORE_BIT];
         n.rx_stamp = pwdata[`CEF_CTRL_RXTS_BIT];
         n.ev_stamp = pwdata[`CEF_CTRL_EVTS_BIT];
         n.psize    = pwdata[`CEF_CTRL_PSZ_MSB:`CEF_CTRL_PSZ_LSB];
      end

      // Capture a frame; unused positions are left zero
      case (r.st)
         CEF_ST_IDLE: begin
            if (rx_take) begin
               n.w0 = '0;
               n.w0[`CEF_W0_STD_MSB:`CEF_W0_STD_LSB] = rx_std_identifier;
               n.w0[`CEF_W0_EXT_MSB:`CEF_W0_EXT_LSB] = rx_ext_identifier;
               n.w0[`CEF_W0_HIGH_BIT] = rx_std_id_high_bit;
               n.w1 = '0;
               n.w1[`CEF_W1_FILT_MSB:`CEF_W1_FILT_LSB] = rx_filter_match_idx;
               n.w1[`CEF_W1_ESI_BIT] = rx_esi;
               n.w1[`CEF_W1_FDF_BIT] = rx_fdf;
               n.w1[`CEF_W1_BRS_BIT] = rx_brs;
               n.w1[`CEF_W1_RTR_BIT] = rx_rtr;
               n.w1[`CEF_W1_IDE_BIT] = rx_ide;
               n.w1[`CEF_W1_DLC_MSB:`CEF_W1_DLC_LSB] = rx_dlc;
               n.pay      = rx_payload;
               n.stamp    = r.tbase;
               n.is_rx    = 1'b1;
               n.stamp_on = r.rx_stamp;
               n.wlast    = last_word(r.psize);
               n.widx     = '0;
               n.st       = CEF_ST_ID;
            end else if (tx_take && r.ev_store) begin
               n.w0 = '0;
               n.w0[`CEF_W0_STD_MSB:`CEF_W0_STD_LSB] = tx_std_identifier;
               n.w0[`CEF_W0_EXT_MSB:`CEF_W0_EXT_LSB] = tx_ext_identifier;
               n.w0[`CEF_W0_HIGH_BIT] = tx_std_id_high_bit;
               n.w1 = '0;
               n.w1[`CEF_W1_SEQ_MSB:`CEF_W1_SEQ_LSB] = tx_sequence_tag;
               n.w1[`CEF_W1_ESI_BIT] = tx_esi;
               n.w1[`CEF_W1_FDF_BIT] = tx_fdf;
               n.w1[`CEF_W1_BRS_BIT] = tx_brs;
               n.w1[`CEF_W1_RTR_BIT] = tx_rtr;
               n.w1[`CEF_W1_IDE_BIT] = tx_ide;
               n.w1[`CEF_W1_DLC_MSB:`CEF_W1_DLC_LSB] = tx_dlc;
               n.stamp    = r.tbase;
               n.is_rx    = 1'b0;
               n.stamp_on = r.ev_stamp;
               n.st       = CEF_ST_ID;
            end
         end
         // Each emitting state waits while the FIFO is full
         CEF_ST_ID: begin
            if (push_ready) begin
               n.st = CEF_ST_FLAGS;
            end
         end
         CEF_ST_FLAGS: begin
            if (push_ready) begin
               if (r.stamp_on) begin
                  n.st = CEF_ST_STAMP;
               end else if (r.is_rx) begin
                  n.st = CEF_ST_DATA;
               end else begin
                  n.st = CEF_ST_IDLE;
               end
            end
         end
         CEF_ST_STAMP: begin
            if (push_ready) begin
               n.st = r.is_rx ? CEF_ST_DATA : CEF_ST_IDLE;
            end
         end
         CEF_ST_DATA: begin
            if (push_ready) begin
               if (r.widx == r.wlast) begin
                  n.st = CEF_ST_IDLE;
               end else begin
                  n.widx = r.widx + 4'h1;
               end
            end
         end
         default: begin
            n.st = CEF_ST_IDLE;
         end
      endcase

      // Objects completed, counted as the last word enters the FIFO
      if (push_valid && push_ready && push_last) begin
         if (r.is_rx) begin
            n.n_rx = r.n_rx + 16'h1;
         end else begin
            n.n_ev = r.n_ev + 16'h1;
         end
      end

      // Ready only while idle and not just taking a frame
      n.rx_ready = (n.st == CEF_ST_IDLE) & ~rx_take & ~tx_take;
      n.tx_ready = n.rx_ready;

      // Output stage: holds a word until the RAM side takes it
      if (fifo_pop) begin
         n.ov    = 1'b1;
         n.od    = fifo_data[31:0];
         n.ol    = fifo_data[32];
         n.okind = fifo_data[33];
      end else if (obj_word_ready) begin
         n.ov = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r          <= '0;
         r.st       <= CEF_ST_IDLE;
         r.ev_store <= `CEF_RST_CTRL_STORE;
         r.rx_stamp <= `CEF_RST_CTRL_RXTS;
         r.ev_stamp <= `CEF_RST_CTRL_EVTS;
         r.psize    <= `CEF_RST_CTRL_PSZ;
      end else begin
         r <= n;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Word buffer; a stalled RAM side fills it and stalls the sequencer
   cef_fifo #(
      .WIDTH (FW),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .pclk      (pclk),
      .presetn   (presetn),
      .in_valid  (push_valid),
      .in_ready  (push_ready),
      .in_data   ({r.is_rx, push_last, push_word}),
      .out_valid (fifo_valid),
      .out_ready (fifo_pop),
      .out_data  (fifo_data)
   );

   // Outputs straight from the state register
   assign prdata         = r.prdata;
   assign pready         = r.pready;
   assign pslverr        = r.pslverr;
   assign rx_frame_ready = r.rx_ready;
   assign tx_event_ready = r.tx_ready;
   assign obj_word_valid = r.ov;
   assign obj_word_data  = r.od;
   assign obj_word_last  = r.ol;
   assign obj_word_is_rx = r.okind;

endmodule

// ### testbench/cef_object_writer_asserts.sv
// Concurrent checks on the object formatter top-level ports
`timescale 1ns/1ps
`include "cef_consts.svh"
module cef_object_writer_asserts (
   // Clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // APB register port
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Frame handshakes
   input wire logic        rx_frame_valid,
   input wire logic        rx_frame_ready,
   input wire logic        tx_event_valid,
   input wire logic        tx_event_ready,
   // Object word stream
   input wire logic        obj_word_valid,
   input wire logic        obj_word_ready,
   input wire logic [31:0] obj_word_data,
   input wire logic        obj_word_last,
   input wire logic        obj_word_is_rx
);
   logic [4:0] widx;
   logic       ev_on;

   default clocking dc @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   ////////////////////////////////////////////////////////////////////////////////
   // Word position in the current object; snoop of the event store enable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         widx  <= 5'h00;
         ev_on <= 1'b0;
      end else begin
         if (obj_word_valid && obj_word_ready)
            widx <= obj_word_last ? 5'h00 : widx + 5'h01;
         if (psel && penable && pready && pwrite && !pslverr && paddr == `CEF_REG_CTRL)
            ev_on <= pwdata[0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Object layout
   AST_W0_TOP: assert property (obj_word_valid && widx == 5'h00
      |-> obj_word_data[31:30] == 2'b00) else $error("word 0 unused bits set");
   AST_RX_W1_GAP: assert property (obj_word_valid && obj_word_is_rx && widx == 5'h01
      |-> obj_word_data[31:16] == 16'h0000 && obj_word_data[10:9] == 2'b00)
      else $error("receive word 1 unused bits set");
   AST_RX_LEN: assert property (obj_word_valid && obj_word_is_rx && obj_word_last
      |-> widx inside {[5'h03:5'h0a], 5'h0d, 5'h0e, 5'h11, 5'h12})
      else $error("receive object length wrong");
   AST_EV_LEN: assert property (obj_word_valid && !obj_word_is_rx && obj_word_last
      |-> widx == 5'h01 || widx == 5'h02) else $error("event object length wrong");
   AST_EV_GATED: assert property (obj_word_valid && !obj_word_is_rx |-> ev_on)
      else $error("event word while not stored");
   AST_HOLD: assert property (obj_word_valid && !obj_word_ready |=> obj_word_valid
      && $stable(obj_word_data) && $stable(obj_word_last) && $stable(obj_word_is_rx))
      else $error("stalled word changed");
   // Handshakes
   AST_RX_TAKE: assert property (rx_frame_valid && rx_frame_ready |=> !rx_frame_ready [*3])
      else $error("receive ready back too soon");
   AST_TX_TAKE: assert property (tx_event_valid && tx_event_ready && !rx_frame_valid
      |=> !tx_event_ready) else $error("event ready did not drop");
   AST_APB_WAIT: assert property ($rose(penable) |-> !pready ##1 pready)
      else $error("apb wait state wrong");
   AST_ERR_PULSE: assert property (pslverr |-> pready ##1 !pready)
      else $error("slave error without answer");
endmodule

bind cef_object_writer cef_object_writer_asserts chk_u (
   .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
   .rx_frame_valid, .rx_frame_ready, .tx_event_valid, .tx_event_ready,
   .obj_word_valid, .obj_word_ready, .obj_word_data, .obj_word_last, .obj_word_is_rx
);

// ### testbench/cef_ram_sink.sv
// Message RAM side model: takes object words, optionally stalling
`timescale 1ns/1ps
module cef_ram_sink (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // Object word stream
   input  wire logic        obj_word_valid,
   output      logic        obj_word_ready,
   input  wire logic [31:0] obj_word_data,
   input  wire logic        obj_word_last,
   input  wire logic        obj_word_is_rx,
   // Bench control
   input  wire logic        stall
);
   logic [1:0]  tick;
   logic [33:0] q[$];

   // One take in four while stalling, so the formatter FIFO backs up
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick           <= 2'h0;
         obj_word_ready <= 1'b0;
      end else begin
         tick           <= tick + 2'h1;
         obj_word_ready <= !stall || tick == 2'h3;
         if (obj_word_valid && obj_word_ready)
            q.push_back({obj_word_is_rx, obj_word_last, obj_word_data});
      end
   end
endmodule

// ### testbench/cef_object_writer_test.sv
// Self-checking bench for the object formatter
`timescale 1ns/1ps
`include "cef_consts.svh"
module cef_object_writer_test import cef_pkg::*;;
   logic         pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0]  paddr = 12'h000;
   logic [31:0]  pwdata = 32'h0, prdata, tb_cnt;
   logic         pready, pslverr, rx_frame_ready, tx_event_ready, stall = 1'b0;
   logic         rx_frame_valid = 1'b0, rx_std_id_high_bit = 1'b0, rx_esi = 1'b0;
   logic         tx_event_valid = 1'b0, tx_std_id_high_bit = 1'b0, tx_esi = 1'b0;
   logic [10:0]  rx_std_identifier = 11'h0, tx_std_identifier = 11'h0;
   logic [17:0]  rx_ext_identifier = 18'h0, tx_ext_identifier = 18'h0;
   logic [4:0]   rx_filter_match_idx = 5'h0;
   logic [22:0]  tx_sequence_tag = 23'h0;
   logic [3:0]   rx_flg = 4'h0, rx_dlc = 4'h0, tx_flg = 4'h0, tx_dlc = 4'h0;
   logic [511:0] rx_payload = '0;
   logic         obj_word_valid, obj_word_ready, obj_word_last, obj_word_is_rx;
   logic [31:0]  obj_word_data;
   logic         store_on = 1'b0, rx_st = 1'b0, ev_st = 1'b0;
   logic [2:0]   psz = 3'h0;
   logic [33:0]  exp_q[$], got, e;
   int           nwords[8] = '{2, 3, 4, 5, 6, 8, 12, 16};
   int           n_fail = 0, checked = 0, cyc = 0;

   cef_object_writer #(.FIFO_DEPTH(4)) dut_u (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .rx_frame_valid, .rx_frame_ready, .rx_std_identifier, .rx_ext_identifier,
      .rx_std_id_high_bit, .rx_filter_match_idx, .rx_esi, .rx_fdf(rx_flg[3]),
      .rx_brs(rx_flg[2]), .rx_rtr(rx_flg[1]), .rx_ide(rx_flg[0]), .rx_dlc, .rx_payload,
      .tx_event_valid, .tx_event_ready, .tx_std_identifier, .tx_ext_identifier,
      .tx_std_id_high_bit, .tx_sequence_tag, .tx_esi, .tx_fdf(tx_flg[3]),
      .tx_brs(tx_flg[2]), .tx_rtr(tx_flg[1]), .tx_ide(tx_flg[0]), .tx_dlc,
      .obj_word_valid, .obj_word_ready, .obj_word_data, .obj_word_last, .obj_word_is_rx
   );
   cef_ram_sink sink_u (
      .pclk, .presetn, .obj_word_valid, .obj_word_ready, .obj_word_data,
      .obj_word_last, .obj_word_is_rx, .stall
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Clock, reference time base and hang guard
   always #5 pclk = ~pclk;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         tb_cnt <= 32'h0;
      else
         tb_cnt <= tb_cnt + 32'h1;
   end
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         n_fail++;
         conclude();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Comparisons and verdict
   task automatic chk32(input logic [31:0] g, x);
      checked++;
      if (g !== x) begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, g, x);
      end
   endtask
   task automatic chk1(input logic g, x);
      chk32({31'h0, g}, {31'h0, x});
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // APB master; on a read, d is the expected data and only rides on pwdata
   task automatic reg_io(input logic wr, input logic [11:0] a, input logic [31:0] d,
                         input logic xe);
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      if (!wr)
         chk32(prdata, d);
      chk1(pslverr, xe);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   // Shadow copy of the control word for the expected object shape
   task automatic cfg(input logic s, r, v, input logic [2:0] p);
      store_on = s;
      rx_st    = r;
      ev_st    = v;
      psz      = p;
      reg_io(1'b1, `CEF_REG_CTRL, {25'h0, p, 1'b0, v, r, s}, 1'b0);
   endtask
   task automatic put(input logic k, l, input logic [31:0] d);
      exp_q.push_back({k, l, d});
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Frame sources; words are queued at the take edge, where tb_cnt holds the stamp
   task automatic send_rx(input int i);
      int n;
      n = nwords[psz];
      @(posedge pclk);
      rx_frame_valid      <= 1'b1;
      rx_std_identifier   <= 11'(i * 37 + 5);
      rx_ext_identifier   <= 18'(i * 4321 + 7);
      rx_std_id_high_bit  <= i[0];
      rx_filter_match_idx <= 5'(i * 7 + 3);
      rx_esi              <= i[1];
      rx_flg              <= 4'(i + 5);
      rx_dlc              <= 4'(15 - i);
      for (int j = 0; j < 64; j++)
         rx_payload[8*j +: 8] <= 8'(j * 5 + i);
      do @(posedge pclk); while (rx_frame_ready !== 1'b1);
      rx_frame_valid <= 1'b0;
      put(1'b1, 1'b0, {2'b00, rx_std_id_high_bit, rx_ext_identifier, rx_std_identifier});
      put(1'b1, 1'b0, {16'h0, rx_filter_match_idx, 2'b00, rx_esi, rx_flg, rx_dlc});
      if (rx_st)
         put(1'b1, 1'b0, tb_cnt);
      for (int k = 0; k < n; k++)
         put(1'b1, k == n - 1, rx_payload[32*k +: 32]);
   endtask
   task automatic send_tx(input int i);
      @(posedge pclk);
      tx_event_valid     <= 1'b1;
      tx_std_identifier  <= 11'(i * 91 + 2);
      tx_ext_identifier  <= 18'(i * 5003 + 1);
      tx_std_id_high_bit <= ~i[0];
      tx_sequence_tag    <= 23'h400000 | 23'(i * 321);
      tx_esi             <= ~i[1];
      tx_flg             <= 4'(9 - i);
      tx_dlc             <= 4'(i + 3);
      do @(posedge pclk); while (tx_event_ready !== 1'b1 || rx_frame_valid !== 1'b0);
      tx_event_valid <= 1'b0;
      if (store_on) begin
         put(1'b0, 1'b0, {2'b00, tx_std_id_high_bit, tx_ext_identifier, tx_std_identifier});
         put(1'b0, !ev_st, {tx_sequence_tag, tx_esi, tx_flg, tx_dlc});
         if (ev_st)
            put(1'b0, 1'b1, tb_cnt);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      reg_io(1'b0, `CEF_REG_CTRL, 32'h0, 1'b0);
      reg_io(1'b0, `CEF_REG_STATUS, 32'h0, 1'b0);
      reg_io(1'b0, 12'h00c, 32'h0, 1'b1);
      reg_io(1'b1, `CEF_REG_STATUS, 32'hffff_ffff, 1'b1);
      reg_io(1'b0, `CEF_REG_STATUS, 32'h0, 1'b0);
      reg_io(1'b1, `CEF_REG_CTRL, 32'hffff_ffff, 1'b0);
      reg_io(1'b0, `CEF_REG_CTRL, 32'h0000_0077, 1'b0);
      cfg(1'b0, 1'b0, 1'b0, 3'h0);
      send_tx(1);
      repeat (20) @(posedge pclk);
      chk32(32'(sink_u.q.size()), 32'h0);
      // Every payload size code, stamps toggled, sink stalling on half of them
      for (int p = 0; p < 8; p++) begin
         cfg(1'b1, p[0], !p[0], 3'(p));
         stall <= p[1];
         send_rx(p);
         send_tx(p);
      end
      // Both sources at once: the receive frame must come out first
      fork
         send_rx(9);
         send_tx(9);
      join
      while (sink_u.q.size() < exp_q.size())
         @(posedge pclk);
      while (exp_q.size() > 0) begin
         got = sink_u.q.pop_front();
         e   = exp_q.pop_front();
         chk32(got[31:0], e[31:0]);
         chk1(got[32], e[32]);
         chk1(got[33], e[33]);
      end
      reg_io(1'b0, `CEF_REG_STATUS, {16'd9, 16'd9}, 1'b0);
      conclude();
   end
endmodule
